/* bench/sbr_exec_chk.sv */
// checker: execute block results and timing
`default_nettype none
module sbr_exec_chk
  import sbr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic insnValid,
  input wire logic carryIn,
  input wire logic busy,
  input wire logic pcLoad,
  input wire logic stackPop,
  input wire logic regWrEn,
  input wire logic flushNext,
  input wire logic carryWrEn,
  input wire logic carryOut,
  input wire logic [13:0] insnWord,
  input wire logic [7:0] regRdData,
  input wire logic [7:0] pcHighLatch,
  input wire logic [7:0] wOut,
  input wire logic [7:0] regWrData,
  input wire logic [12:0] stackTop,
  input wire logic [12:0] pcOut,
  input wire logic [6:0] regAddr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire tk = insnValid && !busy;
  wire dec = tk && insnWord[13:8] == OP_DEC_SKIP;
  wire rot = tk && insnWord[13:8] == OP_ROT_LEFT;
  property p_jump; tk && insnWord[13:11] == OP_JUMP |=> pcLoad && flushNext && busy
    && pcOut == {$past(pcHighLatch[4:3]), $past(insnWord[10:0])}; endproperty
  a_jump: assert property (p_jump) else $error("jump");
  property p_ret; tk && insnWord[13:10] == OP_RET_LIT |=> stackPop && pcLoad && flushNext
    && pcOut == $past(stackTop) && wOut == $past(insnWord[7:0]); endproperty
  a_ret: assert property (p_ret) else $error("return");
  property p_rot; rot |=> carryWrEn && !flushNext && carryOut == $past(regRdData[7]); endproperty
  a_rot: assert property (p_rot) else $error("rotate carry");
  property p_rotw; rot && !insnWord[7] |=> wOut == {$past(regRdData[6:0]), $past(carryIn)}; endproperty
  a_rotw: assert property (p_rotw) else $error("rotate w");
  property p_rotf; rot && insnWord[7] |=> regWrEn && regWrData == {$past(regRdData[6:0]), $past(carryIn)}; endproperty
  a_rotf: assert property (p_rotf) else $error("rotate f");
  property p_dec; dec && insnWord[7] |=> regWrEn && !carryWrEn && regWrData == $past(regRdData) - 8'h01; endproperty
  a_dec: assert property (p_dec) else $error("decrement");
  property p_skip; dec |=> flushNext == ($past(regRdData) == 8'h01); endproperty
  a_skip: assert property (p_skip) else $error("skip");
  property p_drop; insnValid && busy |=> !regWrEn && !pcLoad && !busy; endproperty
  a_drop: assert property (p_drop) else $error("discard");
  property p_addr; insnValid |-> regAddr == insnWord[6:0]; endproperty
  a_addr: assert property (p_addr) else $error("register address");
endmodule : sbr_exec_chk
bind sbr_exec sbr_exec_chk u_chk (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .insnValid(insnValid),
  .carryIn(carryIn),
  .busy(busy),
  .pcLoad(pcLoad),
  .stackPop(stackPop),
  .regWrEn(regWrEn),
  .flushNext(flushNext),
  .carryWrEn(carryWrEn),
  .carryOut(carryOut),
  .insnWord(insnWord),
  .regRdData(regRdData),
  .pcHighLatch(pcHighLatch),
  .wOut(wOut),
  .regWrData(regWrData),
  .stackTop(stackTop),
  .pcOut(pcOut),
  .regAddr(regAddr)
);
`default_nettype wire

/* bench/sbr_exec_tb.sv */
// testbench: execute block against register file model
`default_nettype none
module sbr_exec_tb import sbr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_n = 0, insnValid = 0, carryIn = 0, regWrEn, pcLoad, stackPop, carryOut, carryWrEn;
  logic flushNext, busy;
  logic [13:0] insnWord = 14'h0000;
  logic [12:0] stackTop = 13'h0123, pcOut;
  logic [7:0] pcHighLatch = 8'h18, regRdData, regWrData, wOut;
  logic [6:0] regAddr;
  int errors = 0, checks_done = 0;
  sbr_exec dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .insnValid(insnValid),
    .insnWord(insnWord),
    .regRdData(regRdData),
    .stackTop(stackTop),
    .pcHighLatch(pcHighLatch),
    .carryIn(carryIn),
    .regAddr(regAddr),
    .regWrEn(regWrEn),
    .regWrData(regWrData),
    .pcOut(pcOut),
    .pcLoad(pcLoad),
    .stackPop(stackPop),
    .wOut(wOut),
    .carryOut(carryOut),
    .carryWrEn(carryWrEn),
    .flushNext(flushNext),
    .busy(busy)
  );
  sbr_regfile_model u_rf (
    .ref_clk(ref_clk),
    .regAddr(regAddr),
    .regWrEn(regWrEn),
    .regWrData(regWrData),
    .regRdData(regRdData)
  );
  task chk(input string n, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task issue(input logic [13:0] w, input logic c);
    @(posedge ref_clk);
    insnValid <= 1'b1;
    insnWord <= w;
    carryIn <= c;
    @(posedge ref_clk);
    insnValid <= 1'b0;
    #1;
  endtask : issue
  task t_dec;
    u_rf.mem[5] = 8'h01;
    issue(14'h0B85, 1'b0);
    chk("dec", 16'h0100, {7'h00, regWrEn, regWrData});
    chk("skip", 16'h0001, {15'h0000, flushNext});
    issue(14'h0B85, 1'b0);
    chk("dropped", 16'h0000, {14'h0000, regWrEn, busy});
    issue(14'h0B05, 1'b0);
    chk("dec w", 16'h00FF, {flushNext, carryWrEn, 6'h00, wOut});
  endtask : t_dec
  task t_jump;
    issue(14'h2ABC, 1'b0);
    chk("jump", 16'hFABC, {pcLoad, busy, 1'b1, pcOut});
    issue(14'h37A5, 1'b0);
    chk("jump drop", 16'h0000, {14'h0000, pcLoad, stackPop});
  endtask : t_jump
  task t_ret;
    issue(14'h37A5, 1'b0);
    chk("ret pc", 16'hC123, {stackPop, pcLoad, 1'b0, pcOut});
    chk("ret w", 16'h00A5, {8'h00, wOut});
    issue(14'h0000, 1'b0);
  endtask : t_ret
  task t_rot;
    u_rf.mem[9] = 8'hE6;
    issue(14'h0D09, 1'b0);
    chk("rot w", 16'h03CC, {5'h00, flushNext, carryWrEn, carryOut, wOut});
    issue(14'h0D89, 1'b1);
    chk("rot f", 16'h01CD, {7'h00, regWrEn, regWrData});
  endtask : t_rot
  task t_reset;
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk("reset w", 16'h0000, {7'h00, carryOut, wOut});
    chk("reset pc", 16'h0000, {busy, flushNext, pcLoad, pcOut});
  endtask : t_reset
  task wrap_up;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  initial forever #5 ref_clk = ~ref_clk;
  initial begin
    #20000;
    errors++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_dec();
    t_jump();
    t_ret();
    t_rot();
    t_reset();
    wrap_up();
  end
endmodule : sbr_exec_tb
`default_nettype wire

/* bench/sbr_regfile_model.sv */
// model: register file with latched write address
`default_nettype none
module sbr_regfile_model (
  input wire logic ref_clk,
  input wire logic [6:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [128];
  logic [6:0] lastAddr;
  assign regRdData = mem[regAddr];
  always @(posedge ref_clk) begin
    lastAddr <= regAddr;
    if (regWrEn) mem[lastAddr] <= regWrData;
  end
endmodule : sbr_regfile_model
`default_nettype wire

/* design/sbr_exec.sv */
// module: executes decrement-skip, jump, return-literal and rotate-left
`default_nettype none
module sbr_op_match
  import sbr_pkg::*;
#(
  parameter int FIELD_W = 6
) (
  input wire logic [FIELD_W-1:0] field,
  input wire logic [FIELD_W-1:0] pattern,
  output logic hit
);
  assign hit = field == pattern;
endmodule : sbr_op_match

module sbr_dest_route
  import sbr_pkg::*;
(
  input wire logic enable,
  input wire logic toFile,
  output logic fileWr,
  output logic workWr
);
  assign fileWr = enable && toFile;
  assign workWr = enable && !toFile;
endmodule : sbr_dest_route

module sbr_exec
  import sbr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic insnValid,
  input wire logic [INSN_W-1:0] insnWord,
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic [PC_W-1:0] stackTop,
  input wire logic [DATA_W-1:0] pcHighLatch,
  input wire logic carryIn,
  output logic [ADDR_W-1:0] regAddr,
  output logic regWrEn,
  output logic [DATA_W-1:0] regWrData,
  output logic [PC_W-1:0] pcOut,
  output logic pcLoad,
  output logic stackPop,
  output logic [DATA_W-1:0] wOut,
  output logic carryOut,
  output logic carryWrEn,
  output logic flushNext,
  output logic busy
);
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic pcLoad;
    logic stackPop;
    logic [DATA_W-1:0] w;
    logic carry;
    logic carryWr;
    logic regWr;
    logic [DATA_W-1:0] regWrData;
    logic flush;
    logic discard;
  } sbr_state_t;

  sbr_state_t state_reg;
  sbr_state_t state_next;
  typedef enum logic [4:0] {
    INSN_NONE = 5'h01,
    INSN_DEC = 5'h02,
    INSN_ROT = 5'h04,
    INSN_JUMP = 5'h08,
    INSN_RET = 5'h10
  } sbr_insn_t;

  sbr_insn_t insnClass;
  logic isDec;
  logic isRot;
  logic isJump;
  logic isRet;
  logic destF;
  logic [DATA_W-1:0] decValue;
  logic [DATA_W-1:0] rotValue;
  logic [PC_W-1:0] jumpTarget;
  logic decZero;
  logic rotCarry;
  logic execNow;
  logic decFileWr;
  logic decWorkWr;
  logic rotFileWr;
  logic rotWorkWr;

  // opcode field matchers
  sbr_op_match #(
    .FIELD_W($bits(OP_DEC_SKIP))
  ) u_match_dec (
    .field(insnWord[OPC_MSB:OP_ALU_LSB]),
    .pattern(OP_DEC_SKIP),
    .hit(isDec)
  );
  sbr_op_match #(
    .FIELD_W($bits(OP_ROT_LEFT))
  ) u_match_rot (
    .field(insnWord[OPC_MSB:OP_ALU_LSB]),
    .pattern(OP_ROT_LEFT),
    .hit(isRot)
  );
  sbr_op_match #(
    .FIELD_W($bits(OP_JUMP))
  ) u_match_jump (
    .field(insnWord[OPC_MSB:OP_JUMP_LSB]),
    .pattern(OP_JUMP),
    .hit(isJump)
  );
  sbr_op_match #(
    .FIELD_W($bits(OP_RET_LIT))
  ) u_match_ret (
    .field(insnWord[OPC_MSB:OP_RET_LSB]),
    .pattern(OP_RET_LIT),
    .hit(isRet)
  );

  always_comb begin
    insnClass = INSN_NONE;
    if (isDec) begin
      insnClass = INSN_DEC;
    end else if (isRot) begin
      insnClass = INSN_ROT;
    end else if (isJump) begin
      insnClass = INSN_JUMP;
    end else if (isRet) begin
      insnClass = INSN_RET;
    end
  end

  assign destF = insnWord[DEST_BIT];
  assign decValue = regRdData - 8'h01;
  assign decZero = decValue == '0;
  assign rotValue = {regRdData[DATA_W-2:0], carryIn};
  assign rotCarry = regRdData[DATA_W-1];
  assign jumpTarget = {
    pcHighLatch[LATCH_LO+1:LATCH_LO],
    insnWord[JUMP_K_W-1:0]
  };
  assign execNow = insnValid && !state_reg.discard;
  assign regAddr = insnWord[ADDR_W-1:0];

  // destination select shared by decrement and rotate
  sbr_dest_route u_route_dec (
    .enable(execNow && insnClass == INSN_DEC),
    .toFile(destF),
    .fileWr(decFileWr),
    .workWr(decWorkWr)
  );
  sbr_dest_route u_route_rot (
    .enable(execNow && insnClass == INSN_ROT),
    .toFile(destF),
    .fileWr(rotFileWr),
    .workWr(rotWorkWr)
  );

  always_comb begin
    state_next = state_reg;
    state_next.pcLoad = 1'b0;
    state_next.stackPop = 1'b0;
    state_next.carryWr = 1'b0;
    state_next.regWr = 1'b0;
    state_next.flush = 1'b0;
    if (insnValid) begin
      state_next.discard = 1'b0;
    end
    if (execNow) begin
      unique case (insnClass)
        INSN_DEC: begin
          if (decFileWr) begin
            state_next.regWr = 1'b1;
            state_next.regWrData = decValue;
          end
          if (decWorkWr) begin
            state_next.w = decValue;
          end
          if (decZero) begin
            state_next.flush = 1'b1;
            state_next.discard = 1'b1;
          end
        end
        INSN_ROT: begin
          state_next.carry = rotCarry;
          state_next.carryWr = 1'b1;
          if (rotFileWr) begin
            state_next.regWr = 1'b1;
            state_next.regWrData = rotValue;
          end
          if (rotWorkWr) begin
            state_next.w = rotValue;
          end
        end
        INSN_JUMP: begin
          state_next.pc = jumpTarget;
          state_next.pcLoad = 1'b1;
          state_next.flush = 1'b1;
          state_next.discard = 1'b1;
        end
        INSN_RET: begin
          state_next.w = insnWord[DATA_W-1:0];
          state_next.pc = stackTop;
          state_next.pcLoad = 1'b1;
          state_next.stackPop = 1'b1;
          state_next.flush = 1'b1;
          state_next.discard = 1'b1;
        end
        INSN_NONE: begin
          // unknown words are ignored
        end
      endcase
    end
    if (!rst_n) begin
      state_next = '0;
      state_next.pc = PC_RESET;
      state_next.w = W_RESET;
    end
  end

  always_ff @(posedge ref_clk) begin
    state_reg <= state_next;
  end

  assign regWrEn = state_reg.regWr;
  assign regWrData = state_reg.regWrData;
  assign pcOut = state_reg.pc;
  assign pcLoad = state_reg.pcLoad;
  assign stackPop = state_reg.stackPop;
  assign wOut = state_reg.w;
  assign carryOut = state_reg.carry;
  assign carryWrEn = state_reg.carryWr;
  assign flushNext = state_reg.flush;
  assign busy = state_reg.discard;
endmodule : sbr_exec
`default_nettype wire

/* design/sbr_pkg.sv */
// package: opcodes, fields and reset values for the execute block
//
// Contract
// - decrement_skip_zero writes f minus one to W when d=0, else to f.
// - zero result discards the fetched next word, executes a no-op: two cycles.
// - jump_immediate loads its 11-bit immediate into PC bits 10..0.
// - jump_immediate fills PC bits 12..11 from pc_high_latch bits 4..3.
// - jump_immediate always taken, one word, two cycles.
// - return_with_literal loads W with the low byte; x opcode bits ignored.
// - return_with_literal pops stack_top into PC, takes two cycles.
// - rotate_left_carry shifts f left through carry in one cycle.
// - rotate result goes to W when d=0, back to f when d=1.
// - decrement_skip_zero decoded from 00 1011 dfff ffff, flags unchanged.
`default_nettype none
package sbr_pkg;
  localparam int INSN_W = 14;
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int DEST_BIT = 7;
  localparam int JUMP_K_W = 11;
  localparam int LATCH_LO = 3;
  localparam int OPC_MSB = 13;
  localparam int OP_ALU_LSB = 8;
  localparam int OP_JUMP_LSB = 11;
  localparam int OP_RET_LSB = 10;
  localparam logic [5:0] OP_DEC_SKIP = 6'h0B;
  localparam logic [5:0] OP_ROT_LEFT = 6'h0D;
  localparam logic [2:0] OP_JUMP = 3'h5;
  localparam logic [3:0] OP_RET_LIT = 4'hD;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;
endpackage : sbr_pkg
`default_nettype wire
